// file: tcc_pkg.sv
// Constants, field layout and types of the three-channel timer
package tcc_pkg;
	localparam logic [15:0] ADDR_TIMER_CTL = 16'h0160;
	localparam logic [15:0] ADDR_CH0_CTL = 16'h0162;
	localparam logic [15:0] ADDR_CH1_CTL = 16'h0164;
	localparam logic [15:0] ADDR_CH2_CTL = 16'h0166;
	localparam logic [15:0] ADDR_IVEC = 16'h016E;
	localparam logic [15:0] ADDR_CNT = 16'h0170;
	localparam logic [15:0] ADDR_CH0_VAL = 16'h0172;
	localparam logic [15:0] ADDR_CH1_VAL = 16'h0174;
	localparam logic [15:0] ADDR_CH2_VAL = 16'h0176;
	localparam int TC_SRC_LSB = 8;
	localparam int TC_MODE_LSB = 4;
	localparam int TC_CLR_BIT = 2;
	localparam int TC_IE_BIT = 1;
	localparam int TC_IFG_BIT = 0;
	localparam logic [15:0] TC_WMASK = 16'h0332;
	localparam int CC_CM_LSB = 14;
	localparam int CC_IS_LSB = 12;
	localparam int CC_CAP_BIT = 8;
	localparam int CC_OM_LSB = 5;
	localparam int CC_IE_BIT = 4;
	localparam int CC_CCI_BIT = 3;
	localparam int CC_OUT_BIT = 2;
	localparam int CC_OV_BIT = 1;
	localparam int CC_IFG_BIT = 0;
	localparam logic [15:0] CC_WMASK = 16'hF1F4;
	localparam logic [15:0] TCTL_RST = 16'h0000;
	localparam logic [15:0] CCTL_RST = 16'h0000;
	localparam logic [15:0] VAL_RST = 16'h0000;
	localparam logic [15:0] CNT_MAX = 16'hFFFF;
	localparam logic [15:0] IV_NONE = 16'h0000;
	localparam logic [15:0] IV_CH1 = 16'h0002;
	localparam logic [15:0] IV_CH2 = 16'h0004;
	localparam logic [15:0] IV_OVF = 16'h000A;
	localparam int SYNC_W = 9;
	typedef enum logic [1:0] {MODE_STOP = 2'b00, MODE_UP = 2'b01, MODE_CONT = 2'b10,
		MODE_UPB = 2'b11} tcc_mode_t;
	typedef enum logic [1:0] {SRC_EXT = 2'b00, SRC_AUX = 2'b01, SRC_SUB = 2'b10,
		SRC_ALT = 2'b11} tcc_src_t;
	typedef enum logic [1:0] {IS_A = 2'b00, IS_B = 2'b01, IS_GND = 2'b10,
		IS_VCC = 2'b11} tcc_isel_t;
	typedef enum logic [2:0] {OM_BIT = 3'b000, OM_SET = 3'b001, OM_TGL_RST = 3'b010,
		OM_SET_RST = 3'b011, OM_TGL = 3'b100, OM_RST = 3'b101, OM_TGL_SET = 3'b110,
		OM_RST_SET = 3'b111} tcc_omode_t;
endpackage

// file: tcc_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module tcc_sync import tcc_pkg::*; (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [SYNC_W-1:0] din,
	output logic [SYNC_W-1:0] lvl_q
);
	logic [SYNC_W-1:0] s1_q;
	logic [SYNC_W-1:0] s2_q;
	logic [SYNC_W-1:0] s3_q;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= din;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Level changes only once stages two and three agree
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			lvl_q <= '0;
		end else begin
			lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
		end
	end
endmodule

// file: tcc_chan.sv
// One capture/compare channel
`timescale 1ns/1ps
module tcc_chan import tcc_pkg::*; (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic ctl_we,
	input wire logic val_we,
	input wire logic [15:0] wdata,
	input wire logic [15:0] cnt_q,
	input wire logic [15:0] cnt_next,
	input wire logic cnt_tick,
	input wire logic period_ev,
	input wire logic in_a,
	input wire logic in_b,
	input wire logic hw_clr,
	output logic [15:0] ctl_rd,
	output logic [15:0] val_q,
	output logic out_q,
	output logic pend
);
	logic [15:0] ctl_q;
	logic cci;
	logic cci_prev_q;
	logic cap_mode;
	logic cap_ev;
	logic eq_ev;
	logic flag_q;
	logic ov_q;
	tcc_isel_t isel;
	tcc_omode_t omode;

	assign isel = tcc_isel_t'(ctl_q[CC_IS_LSB +: 2]);
	assign omode = tcc_omode_t'(ctl_q[CC_OM_LSB +: 3]);
	assign cap_mode = ctl_q[CC_CAP_BIT];

	always_comb begin
		unique case (isel)
			IS_A: cci = in_a;
			IS_B: cci = in_b;
			IS_GND: cci = 1'b0;
			IS_VCC: cci = 1'b1;
		endcase
	end

	// Capture on selected edge; compare when counter steps onto the value
	assign cap_ev = cap_mode & ((ctl_q[CC_CM_LSB] & cci & ~cci_prev_q)
		| (ctl_q[CC_CM_LSB+1] & ~cci & cci_prev_q));
	assign eq_ev = ~cap_mode & cnt_tick & (cnt_next == val_q);
	assign pend = flag_q & ctl_q[CC_IE_BIT];
	assign ctl_rd = ctl_q | {12'h000, cci, 1'b0, ov_q, flag_q};

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ctl_q <= CCTL_RST;
			cci_prev_q <= 1'b0;
		end else begin
			cci_prev_q <= cci;
			if (ctl_we) begin
				ctl_q <= wdata & CC_WMASK;
			end
		end
	end

	// Hardware set wins over any clear
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			flag_q <= 1'b0;
			ov_q <= 1'b0;
		end else begin
			flag_q <= (cap_ev | eq_ev) | ((ctl_we ? wdata[CC_IFG_BIT] : flag_q) & ~hw_clr);
			ov_q <= (cap_ev & flag_q) | (ctl_we ? wdata[CC_OV_BIT] : ov_q);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			val_q <= VAL_RST;
		end else if (cap_ev) begin
			val_q <= cnt_q;
		end else if (val_we) begin
			val_q <= wdata;
		end
	end

	// Output unit, period event acts as the second edge for PWM
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			out_q <= 1'b0;
		end else begin
			unique case (omode)
				OM_BIT: out_q <= ctl_q[CC_OUT_BIT];
				OM_SET: out_q <= out_q | eq_ev;
				OM_TGL_RST: out_q <= eq_ev ? ~out_q : (period_ev ? 1'b0 : out_q);
				OM_SET_RST: out_q <= eq_ev ? 1'b1 : (period_ev ? 1'b0 : out_q);
				OM_TGL: out_q <= out_q ^ eq_ev;
				OM_RST: out_q <= out_q & ~eq_ev;
				OM_TGL_SET: out_q <= eq_ev ? ~out_q : (period_ev ? 1'b1 : out_q);
				OM_RST_SET: out_q <= eq_ev ? 1'b0 : (period_ev ? 1'b1 : out_q);
			endcase
		end
	end

	property p_capture_value;
		@(posedge clk_sys) disable iff (reset)
		cap_ev |=> (val_q == $past(cnt_q)) && flag_q;
	endproperty
	a_capture_value: assert property (p_capture_value) else $error("capture value lost");

	property p_compare_flag;
		@(posedge clk_sys) disable iff (reset)
		eq_ev |=> flag_q ##0 (pend == ctl_q[CC_IE_BIT]);
	endproperty
	a_compare_flag: assert property (p_compare_flag) else $error("compare flag missing");

	property p_set_output;
		@(posedge clk_sys) disable iff (reset)
		(eq_ev && omode == OM_SET && !ctl_we) |=> out_q ##1 (out_q || $past(ctl_we));
	endproperty
	a_set_output: assert property (p_set_output) else $error("set output failed");

	c_capture: cover property (@(posedge clk_sys) disable iff (reset) cap_ev);
	c_pwm: cover property (@(posedge clk_sys) disable iff (reset)
		omode == OM_RST_SET && eq_ev ##[1:300] period_ev);
endmodule

// file: tcc_top.sv
// Three-channel timer top: word register port, counter, vector
`timescale 1ns/1ps
module tcc_top import tcc_pkg::*; (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [15:0] bus_addr,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic [15:0] bus_wdata,
	output logic [15:0] bus_rdata,
	input wire logic ext_timer_clock,
	input wire logic aux_clock,
	input wire logic submain_clock,
	input wire logic alt_ext_clock,
	input wire logic ch0_in_a,
	input wire logic ch0_in_b,
	input wire logic ch1_in_a,
	input wire logic comparator_output,
	input wire logic ch2_in_a,
	output logic ch0_out,
	output logic ch1_out,
	output logic ch2_out,
	output logic irq_ch0,
	output logic irq_shared
);
	logic [SYNC_W-1:0] lvl;
	logic [15:0] tctl_q;
	logic [15:0] cnt_q;
	logic [15:0] cnt_next;
	logic [15:0] ivec;
	logic [15:0] rd_mux;
	logic [15:0] ctl0_rd;
	logic [15:0] ctl1_rd;
	logic [15:0] ctl2_rd;
	logic [15:0] val0_q;
	logic [15:0] val1_q;
	logic [15:0] val2_q;
	logic ovf_q;
	logic src_lvl;
	logic src_prev_q;
	logic src_rise;
	logic tick;
	logic cnt_wrap;
	logic wrap_ev;
	logic tctl_we;
	logic cnt_we;
	logic ivec_rd;
	logic pend0;
	logic pend1;
	logic pend2;
	logic pend_ovf;
	logic clr1;
	logic clr2;
	logic clr_ovf;
	tcc_mode_t mode;
	tcc_src_t src;

	function automatic logic hit(input logic strobe, input logic [15:0] addr,
		input logic [15:0] reg_addr);
		return strobe && (addr == reg_addr);
	endfunction

	tcc_sync u_sync (
		.clk_sys(clk_sys),
		.reset(reset),
		.din({ch2_in_a, comparator_output, ch1_in_a, ch0_in_b, ch0_in_a,
			alt_ext_clock, submain_clock, aux_clock, ext_timer_clock}),
		.lvl_q(lvl)
	);

	assign tctl_we = hit(bus_wr, bus_addr, ADDR_TIMER_CTL);
	assign cnt_we = hit(bus_wr, bus_addr, ADDR_CNT);
	assign ivec_rd = hit(bus_rd, bus_addr, ADDR_IVEC);
	assign mode = tcc_mode_t'(tctl_q[TC_MODE_LSB +: 2]);
	assign src = tcc_src_t'(tctl_q[TC_SRC_LSB +: 2]);

	// Clock source select and edge detect
	always_comb begin
		unique case (src)
			SRC_EXT: src_lvl = lvl[0];
			SRC_AUX: src_lvl = lvl[1];
			SRC_SUB: src_lvl = lvl[2];
			SRC_ALT: src_lvl = lvl[3];
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			src_prev_q <= 1'b0;
		end else begin
			src_prev_q <= src_lvl;
		end
	end

	assign src_rise = src_lvl & ~src_prev_q;
	assign tick = src_rise && (mode != MODE_STOP) && !cnt_we;

	// Up mode wraps after channel 0 value, continuous after all ones
	always_comb begin
		unique case (mode)
			MODE_CONT: cnt_wrap = (cnt_q == CNT_MAX);
			MODE_STOP: cnt_wrap = 1'b0;
			MODE_UP, MODE_UPB: cnt_wrap = (cnt_q >= val0_q);
		endcase
		cnt_next = cnt_wrap ? 16'h0000 : cnt_q + 16'h0001;
	end

	assign wrap_ev = tick & cnt_wrap;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			cnt_q <= 16'h0000;
		end else if (cnt_we) begin
			cnt_q <= bus_wdata;
		end else if (tctl_we && bus_wdata[TC_CLR_BIT]) begin
			cnt_q <= 16'h0000;
		end else if (tick) begin
			cnt_q <= cnt_next;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			tctl_q <= TCTL_RST;
		end else if (tctl_we) begin
			tctl_q <= bus_wdata & TC_WMASK;
		end
	end

	// Overflow flag, set wins over software or vector clear
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ovf_q <= 1'b0;
		end else begin
			ovf_q <= wrap_ev | ((tctl_we ? bus_wdata[TC_IFG_BIT] : ovf_q) & ~clr_ovf);
		end
	end

	assign pend_ovf = ovf_q & tctl_q[TC_IE_BIT];

	// Vector names highest pending shared source; reading it clears that one
	always_comb begin
		if (pend1) begin
			ivec = IV_CH1;
		end else if (pend2) begin
			ivec = IV_CH2;
		end else if (pend_ovf) begin
			ivec = IV_OVF;
		end else begin
			ivec = IV_NONE;
		end
	end

	assign clr1 = ivec_rd && pend1;
	assign clr2 = ivec_rd && !pend1 && pend2;
	assign clr_ovf = ivec_rd && !pend1 && !pend2 && pend_ovf;
	assign irq_ch0 = pend0;
	assign irq_shared = pend1 | pend2 | pend_ovf;

	tcc_chan u_ch0 (
		.clk_sys(clk_sys),
		.reset(reset),
		.ctl_we(hit(bus_wr, bus_addr, ADDR_CH0_CTL)),
		.val_we(hit(bus_wr, bus_addr, ADDR_CH0_VAL)),
		.wdata(bus_wdata),
		.cnt_q(cnt_q),
		.cnt_next(cnt_next),
		.cnt_tick(tick),
		.period_ev(wrap_ev),
		.in_a(lvl[4]),
		.in_b(lvl[5]),
		.hw_clr(1'b0),
		.ctl_rd(ctl0_rd),
		.val_q(val0_q),
		.out_q(ch0_out),
		.pend(pend0)
	);

	tcc_chan u_ch1 (
		.clk_sys(clk_sys),
		.reset(reset),
		.ctl_we(hit(bus_wr, bus_addr, ADDR_CH1_CTL)),
		.val_we(hit(bus_wr, bus_addr, ADDR_CH1_VAL)),
		.wdata(bus_wdata),
		.cnt_q(cnt_q),
		.cnt_next(cnt_next),
		.cnt_tick(tick),
		.period_ev(wrap_ev),
		.in_a(lvl[6]),
		.in_b(lvl[7]),
		.hw_clr(clr1),
		.ctl_rd(ctl1_rd),
		.val_q(val1_q),
		.out_q(ch1_out),
		.pend(pend1)
	);

	tcc_chan u_ch2 (
		.clk_sys(clk_sys),
		.reset(reset),
		.ctl_we(hit(bus_wr, bus_addr, ADDR_CH2_CTL)),
		.val_we(hit(bus_wr, bus_addr, ADDR_CH2_VAL)),
		.wdata(bus_wdata),
		.cnt_q(cnt_q),
		.cnt_next(cnt_next),
		.cnt_tick(tick),
		.period_ev(wrap_ev),
		.in_a(lvl[8]),
		.in_b(lvl[1]),
		.hw_clr(clr2),
		.ctl_rd(ctl2_rd),
		.val_q(val2_q),
		.out_q(ch2_out),
		.pend(pend2)
	);

	// Read mux, unmapped addresses read zero
	always_comb begin
		case (bus_addr)
			ADDR_TIMER_CTL: rd_mux = tctl_q | {15'h0000, ovf_q};
			ADDR_CH0_CTL: rd_mux = ctl0_rd;
			ADDR_CH1_CTL: rd_mux = ctl1_rd;
			ADDR_CH2_CTL: rd_mux = ctl2_rd;
			ADDR_IVEC: rd_mux = ivec;
			ADDR_CNT: rd_mux = cnt_q;
			ADDR_CH0_VAL: rd_mux = val0_q;
			ADDR_CH1_VAL: rd_mux = val1_q;
			ADDR_CH2_VAL: rd_mux = val2_q;
			default: rd_mux = 16'h0000;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			bus_rdata <= 16'h0000;
		end else if (bus_rd) begin
			bus_rdata <= rd_mux;
		end
	end

	property p_count_step;
		@(posedge clk_sys) disable iff (reset)
		(tick && !cnt_wrap && !tctl_we) |=> cnt_q == $past(cnt_q) + 16'h0001;
	endproperty
	a_count_step: assert property (p_count_step) else $error("counter did not step");

	property p_wrap_flag;
		@(posedge clk_sys) disable iff (reset)
		wrap_ev |=> ovf_q && cnt_q == 16'h0000;
	endproperty
	a_wrap_flag: assert property (p_wrap_flag) else $error("overflow flag missing");

	property p_vector_read;
		@(posedge clk_sys) disable iff (reset)
		(ivec_rd && pend1 && !u_ch1.cap_ev && !u_ch1.eq_ev) |=> bus_rdata == IV_CH1 && !pend1;
	endproperty
	a_vector_read: assert property (p_vector_read) else $error("vector read wrong");

	property p_count_write;
		@(posedge clk_sys) disable iff (reset)
		(cnt_we && mode == MODE_STOP) ##1 (hit(bus_rd, bus_addr, ADDR_CNT) && !cnt_we)
			|=> bus_rdata == $past(bus_wdata, 2);
	endproperty
	a_count_write: assert property (p_count_write) else $error("counter readback wrong");

	property p_src_select;
		@(posedge clk_sys) disable iff (reset)
		(src == SRC_SUB && mode == MODE_CONT && lvl[2] && !src_prev_q && !cnt_we)
			|-> tick;
	endproperty
	a_src_select: assert property (p_src_select) else $error("source edge missed");

	property p_clear_zero;
		@(posedge clk_sys) disable iff (reset)
		(tctl_we && bus_wdata[TC_CLR_BIT]) |=> cnt_q == 16'h0000;
	endproperty
	a_clear_zero: assert property (p_clear_zero) else $error("counter not cleared");

	property p_stop_hold;
		@(posedge clk_sys) disable iff (reset)
		(mode == MODE_STOP && !cnt_we && !tctl_we) |=> cnt_q == $past(cnt_q);
	endproperty
	a_stop_hold: assert property (p_stop_hold) else $error("stopped counter moved");

	property p_vector_ch2;
		@(posedge clk_sys) disable iff (reset)
		(ivec_rd && !pend1 && pend2) |=> bus_rdata == IV_CH2;
	endproperty
	a_vector_ch2: assert property (p_vector_ch2) else $error("vector channel 2 wrong");

	property p_vector_ovf;
		@(posedge clk_sys) disable iff (reset)
		(ivec_rd && !pend1 && !pend2 && pend_ovf && !wrap_ev) |=> bus_rdata == IV_OVF && !ovf_q;
	endproperty
	a_vector_ovf: assert property (p_vector_ovf) else $error("vector overflow wrong");

	property p_rdata_hold;
		@(posedge clk_sys) disable iff (reset)
		!bus_rd |=> $stable(bus_rdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed");

	c_overflow: cover property (@(posedge clk_sys) disable iff (reset) wrap_ev);
	c_vec_ovf: cover property (@(posedge clk_sys) disable iff (reset) ivec_rd && clr_ovf);
	c_vec_ch2: cover property (@(posedge clk_sys) disable iff (reset) ivec_rd && clr2);
endmodule

// file: tcc_top_tb.sv
// Self-checking bench of the three-channel timer
`timescale 1ns/1ps
module tcc_top_tb import tcc_pkg::*;;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic [15:0] bus_addr = 16'h0000;
	logic bus_wr = 1'b0;
	logic bus_rd = 1'b0;
	logic [15:0] bus_wdata = 16'h0000;
	logic [15:0] bus_rdata;
	logic [3:0] src_clk = 4'h0;
	logic ch0_in_a = 1'b0;
	logic ch0_in_b = 1'b0;
	logic ch1_in_a = 1'b0;
	logic comparator_output = 1'b0;
	logic ch2_in_a = 1'b0;
	logic ch0_out, ch1_out, ch2_out, irq_ch0, irq_shared;
	integer seed;
	int bad_count = 0;
	int cmp_count = 0;
	logic [15:0] addr_tab [0:8] = '{ADDR_TIMER_CTL, ADDR_CH0_CTL, ADDR_CH1_CTL, ADDR_CH2_CTL,
		ADDR_IVEC, ADDR_CNT, ADDR_CH0_VAL, ADDR_CH1_VAL, ADDR_CH2_VAL};

	tcc_top tcc_top_i (.clk_sys(clk_sys), .reset(reset), .bus_addr(bus_addr),
		.bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
		.ext_timer_clock(src_clk[0]), .aux_clock(src_clk[1]), .submain_clock(src_clk[2]),
		.alt_ext_clock(src_clk[3]), .ch0_in_a(ch0_in_a), .ch0_in_b(ch0_in_b),
		.ch1_in_a(ch1_in_a), .comparator_output(comparator_output), .ch2_in_a(ch2_in_a),
		.ch0_out(ch0_out), .ch1_out(ch1_out), .ch2_out(ch2_out), .irq_ch0(irq_ch0),
		.irq_shared(irq_shared));

	always #4 clk_sys = ~clk_sys;

	function automatic logic [15:0] rnd16();
		logic [31:0] t;
		t = $random(seed);
		return t[15:0];
	endfunction

	function automatic logic [15:0] tctl(input logic [1:0] src, input logic [1:0] mode,
		input logic clr, input logic ie);
		return {6'b00_0000, src, 2'b00, mode, 1'b0, clr, ie, 1'b0};
	endfunction

	function automatic logic [15:0] cctl(input logic [1:0] cm, input logic [1:0] isel,
		input logic cap, input logic [2:0] om, input logic ie, input logic outb);
		return {cm, isel, 3'b000, cap, om, ie, 1'b0, outb, 2'b00};
	endfunction

	task automatic report_and_stop();
		if (bad_count == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic bus_write(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		bus_wr <= 1'b1;
		bus_addr <= a;
		bus_wdata <= d;
		@(posedge clk_sys);
		bus_wr <= 1'b0;
	endtask

	task automatic bus_read(input logic [15:0] a, output logic [15:0] d);
		@(posedge clk_sys);
		bus_rd <= 1'b1;
		bus_addr <= a;
		@(posedge clk_sys);
		bus_rd <= 1'b0;
		#1;
		d = bus_rdata;
	endtask

	task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
		logic [15:0] d;
		bus_read(a, d);
		chk16(d, exp);
	endtask

	// Write immediately followed by a read of the same word
	task automatic wr_rd_chk(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		bus_wr <= 1'b1;
		bus_addr <= a;
		bus_wdata <= d;
		@(posedge clk_sys);
		bus_wr <= 1'b0;
		bus_rd <= 1'b1;
		@(posedge clk_sys);
		bus_rd <= 1'b0;
		#1;
		chk16(bus_rdata, d);
	endtask

	task automatic do_reset();
		@(posedge clk_sys);
		reset <= 1'b1;
		repeat (5) @(posedge clk_sys);
		reset <= 1'b0;
	endtask

	// Rising edges on one clock source, 4 cycles high and 4 low each
	task automatic pulse(input int src, input int n);
		repeat (n) begin
			src_clk[src] <= 1'b1;
			repeat (4) @(posedge clk_sys);
			src_clk[src] <= 1'b0;
			repeat (4) @(posedge clk_sys);
		end
		repeat (8) @(posedge clk_sys);
	endtask

	task automatic wait_shared();
		int k;
		k = 0;
		while (irq_shared !== 1'b1 && k < 64) begin
			@(posedge clk_sys);
			k++;
		end
		if (irq_shared !== 1'b1) begin
			bad_count++;
			report_and_stop();
		end
	endtask

	initial begin
		logic [15:0] d, g, r, r2;
		int n;
		seed = 32'h37811ccc;
		do_reset();
		for (int i = 0; i < 9; i++) begin
			rd_chk(addr_tab[i], 16'h0000);
		end
		bus_write(16'h0168, rnd16());
		rd_chk(16'h0168, 16'h0000);
		bus_write(ADDR_IVEC, 16'hFFFF);
		rd_chk(ADDR_IVEC, IV_NONE);
		// Counter and value words written and read back to back while stopped
		for (int i = 5; i < 9; i++) begin
			wr_rd_chk(addr_tab[i], rnd16());
		end
		for (int i = 1; i < 4; i++) begin
			d = rnd16();
			bus_write(addr_tab[i], d);
			bus_read(addr_tab[i], g);
			chk16(g & CC_WMASK, d & CC_WMASK);
		end
		d = rnd16();
		bus_write(ADDR_TIMER_CTL, d);
		bus_read(ADDR_TIMER_CTL, g);
		chk16(g, (d & TC_WMASK) | {15'h0000, d[TC_IFG_BIT]});
		do_reset();
		for (int i = 6; i < 9; i++) begin
			bus_write(addr_tab[i], 16'h8000);
		end
		// Every clock source counts its own edges; clear zeroes the counter
		for (int s = 0; s < 4; s++) begin
			n = 1 + int'(rnd16() % 6);
			bus_write(ADDR_TIMER_CTL, tctl(s[1:0], MODE_CONT, 1'b0, 1'b0));
			pulse(s, n);
			rd_chk(ADDR_CNT, 16'(n));
			bus_write(ADDR_TIMER_CTL, tctl(s[1:0], MODE_CONT, 1'b1, 1'b0));
			rd_chk(ADDR_CNT, 16'h0000);
		end
		// Wrap in continuous mode
		bus_write(ADDR_CNT, 16'hFFFE);
		bus_write(ADDR_TIMER_CTL, tctl(SRC_SUB, MODE_CONT, 1'b0, 1'b1));
		pulse(2, 2);
		chk1(irq_shared, 1'b1);
		rd_chk(ADDR_TIMER_CTL, tctl(SRC_SUB, MODE_CONT, 1'b0, 1'b1) | 16'h0001);
		rd_chk(ADDR_IVEC, IV_OVF);
		chk1(irq_shared, 1'b0);
		rd_chk(ADDR_CNT, 16'h0000);
		// Up mode with compares on all channels and vector priority
		bus_write(ADDR_CH0_VAL, 16'h0003);
		bus_write(ADDR_CH1_VAL, 16'h0002);
		bus_write(ADDR_CH2_VAL, 16'h0001);
		bus_write(ADDR_CH0_CTL, cctl(2'b00, IS_A, 1'b0, OM_BIT, 1'b1, 1'b0));
		bus_write(ADDR_CH1_CTL, cctl(2'b00, IS_A, 1'b0, OM_SET, 1'b1, 1'b0));
		bus_write(ADDR_CH2_CTL, cctl(2'b00, IS_A, 1'b0, OM_BIT, 1'b1, 1'b1));
		repeat (3) @(posedge clk_sys);
		chk1(ch2_out, 1'b1);
		chk1(ch1_out, 1'b0);
		bus_write(ADDR_CNT, 16'h0000);
		bus_write(ADDR_TIMER_CTL, tctl(SRC_SUB, MODE_UP, 1'b0, 1'b1));
		pulse(2, 4);
		chk1(ch1_out, 1'b1);
		chk1(irq_ch0, 1'b1);
		chk1(irq_shared, 1'b1);
		rd_chk(ADDR_IVEC, IV_CH1);
		rd_chk(ADDR_IVEC, IV_CH2);
		rd_chk(ADDR_IVEC, IV_OVF);
		rd_chk(ADDR_IVEC, IV_NONE);
		rd_chk(ADDR_CNT, 16'h0000);
		bus_write(ADDR_CH0_CTL, 16'h0000);
		#1;
		chk1(irq_ch0, 1'b0);
		// Capture on channel 0 pin, then overrun
		r = rnd16();
		bus_write(ADDR_TIMER_CTL, tctl(SRC_SUB, MODE_STOP, 1'b0, 1'b0));
		bus_write(ADDR_CNT, r);
		bus_write(ADDR_CH0_CTL, cctl(2'b01, IS_A, 1'b1, OM_BIT, 1'b1, 1'b0));
		ch0_in_a <= 1'b1;
		repeat (8) @(posedge clk_sys);
		rd_chk(ADDR_CH0_VAL, r);
		chk1(irq_ch0, 1'b1);
		rd_chk(ADDR_CH0_CTL, cctl(2'b01, IS_A, 1'b1, OM_BIT, 1'b1, 1'b0) | 16'h0009);
		ch0_in_a <= 1'b0;
		repeat (8) @(posedge clk_sys);
		r2 = rnd16();
		bus_write(ADDR_CNT, r2);
		ch0_in_a <= 1'b1;
		repeat (8) @(posedge clk_sys);
		rd_chk(ADDR_CH0_VAL, r2);
		rd_chk(ADDR_CH0_CTL, cctl(2'b01, IS_A, 1'b1, OM_BIT, 1'b1, 1'b0) | 16'h000B);
		// Channel 1 captures from its alternate input
		r = rnd16();
		bus_write(ADDR_CNT, r);
		bus_write(ADDR_CH1_CTL, cctl(2'b01, IS_B, 1'b1, OM_BIT, 1'b1, 1'b0));
		comparator_output <= 1'b1;
		wait_shared();
		repeat (2) @(posedge clk_sys);
		rd_chk(ADDR_CH1_VAL, r);
		rd_chk(ADDR_IVEC, IV_CH1);
		chk1(irq_shared, 1'b0);
		// Channel 2 captures on a ground to supply select change
		r = rnd16();
		bus_write(ADDR_CNT, r);
		bus_write(ADDR_CH2_CTL, cctl(2'b01, IS_GND, 1'b1, OM_BIT, 1'b0, 1'b0));
		repeat (8) @(posedge clk_sys);
		bus_write(ADDR_CH2_CTL, cctl(2'b01, IS_VCC, 1'b1, OM_BIT, 1'b0, 1'b0));
		repeat (8) @(posedge clk_sys);
		rd_chk(ADDR_CH2_VAL, r);
		// Reset/set output in up mode; channel 0 toggles once per period
		bus_write(ADDR_TIMER_CTL, tctl(SRC_SUB, MODE_STOP, 1'b1, 1'b0));
		bus_write(ADDR_CH0_VAL, 16'h0004);
		bus_write(ADDR_CH1_VAL, 16'h0002);
		bus_write(ADDR_CH0_CTL, cctl(2'b00, IS_A, 1'b0, OM_TGL, 1'b0, 1'b0));
		bus_write(ADDR_CH1_CTL, cctl(2'b00, IS_A, 1'b0, OM_BIT, 1'b0, 1'b1));
		bus_write(ADDR_CH1_CTL, cctl(2'b00, IS_A, 1'b0, OM_RST_SET, 1'b0, 1'b0));
		bus_write(ADDR_TIMER_CTL, tctl(SRC_SUB, MODE_UP, 1'b0, 1'b0));
		pulse(2, 2);
		chk1(ch1_out, 1'b0);
		chk1(ch0_out, 1'b0);
		pulse(2, 3);
		chk1(ch1_out, 1'b1);
		chk1(ch0_out, 1'b1);
		rd_chk(ADDR_CNT, 16'h0000);
		// Channel 0 captures a falling edge on its alternate input
		bus_write(ADDR_TIMER_CTL, tctl(SRC_SUB, MODE_STOP, 1'b0, 1'b0));
		ch0_in_b <= 1'b1;
		repeat (8) @(posedge clk_sys);
		r = rnd16();
		bus_write(ADDR_CNT, r);
		bus_write(ADDR_CH0_CTL, cctl(2'b10, IS_B, 1'b1, OM_BIT, 1'b1, 1'b0));
		ch0_in_b <= 1'b0;
		repeat (8) @(posedge clk_sys);
		rd_chk(ADDR_CH0_VAL, r);
		chk1(irq_ch0, 1'b1);
		report_and_stop();
	end
endmodule
